// >>> hdl/atcr_pkg.sv
// atcr_pkg: offsets, field layout and decode tables of the algorithm tuning register
package atcr_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [7:0]  ATCR_TUNE_INDEX   = 8'ha2;                  // word index
    localparam logic [9:0]  ATCR_TUNE_ADDR    = {ATCR_TUNE_INDEX, 2'b00}; // index times four
    localparam logic [31:0] ATCR_TUNE_RESET   = 32'h0000_0000;
    localparam logic [31:0] ATCR_UNMAPPED_RD  = 32'h0000_0000;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int ATCR_PARITY_BIT   = 31;
    localparam int ATCR_KP_LSB       = 21;
    localparam int ATCR_KI_LSB       = 11;
    localparam int ATCR_GAIN_W       = 10;
    localparam int ATCR_FW_EN_BIT    = 10;
    localparam int ATCR_RAMP_LSB     = 6;
    localparam int ATCR_RAMP_W       = 4;
    localparam int ATCR_SLEW_LSB     = 3;
    localparam int ATCR_SLEW_W       = 3;
    localparam int ATCR_MISC_W       = 3;

    // control modes that pick the unit of the slow ramp
    typedef enum logic [1:0] {
        ATCR_MODE_SPEED,
        ATCR_MODE_POWER,
        ATCR_MODE_TORQUE,
        ATCR_MODE_DUTY
    } atcr_mode_t;

    // slow ramp magnitude in tenths of the mode's base unit, per code 0..f
    localparam logic [14:0] ATCR_RAMP_TENTHS [16] = '{
        15'd1,    15'd10,   15'd20,   15'd30,   15'd50,   15'd100,  15'd200,  15'd300,
        15'd400,  15'd500,  15'd1000, 15'd2000, 15'd5000, 15'd7500, 15'd10000, 15'd20000
    };

    // unit scale of one ramp step, in millionths of the SI-like unit
    // speed: 1 Hz, power: 0.1 W, torque: 0.01 A, duty: 0.001 percent
    localparam logic [19:0] ATCR_UNIT_SPEED_PPM  = 20'd1000000;
    localparam logic [19:0] ATCR_UNIT_POWER_PPM  = 20'd100000;
    localparam logic [19:0] ATCR_UNIT_TORQUE_PPM = 20'd10000;
    localparam logic [19:0] ATCR_UNIT_DUTY_PPM   = 20'd1000;

endpackage : atcr_pkg

// >>> hdl/atcr_gain_decode.sv
// atcr_gain_decode: splits a mantissa/exponent gain into its parts
`timescale 1ns/1ps
module atcr_gain_decode
    import atcr_pkg::*;
(
    input  wire logic [9:0] gain_i,
    output logic      [7:0] mant_o,
    output logic      [1:0] exp10_o
);
    // gain = mantissa * scale / 10^exponent; the scale is left to the consumer
    always_comb begin
        mant_o  = gain_i[7:0];
        exp10_o = gain_i[9:8];
    end
endmodule : atcr_gain_decode

// >>> hdl/atcr_tuning_reg.sv
// atcr_tuning_reg: algorithm tuning config register with a classic wishbone slave
// Operation
// (RULE_01) bits 30:21 hold the field-weakening Kp: 8 lsb * 0.1 / 10^(2 msb).
// (RULE_02) bits 20:11 hold the current-loop Ki: 10 * 8 lsb / 10^(2 msb).
// (RULE_03) bit 10 enables field weakening when one, disables it when zero.
// (RULE_04) bits 9:6 select slow ramp rate from 0.1 to 2000 per second.
// (RULE_05) slow ramp unit follows control mode: speed, power, torque, duty.
// (RULE_06) units scale as 0.1 W, 0.01 A and 0.001 percent.
// (RULE_07) bits 5:3 pick the bus current slew rate during active braking.
// (RULE_08) all fields read/write, reset to zero; bits 2:0 stored as written.
`timescale 1ns/1ps
module atcr_tuning_reg
    import atcr_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // ------------------------------------------------------------------
    // wishbone classic slave
    // ------------------------------------------------------------------
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [9:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // ------------------------------------------------------------------
    // algorithm side
    // ------------------------------------------------------------------
    input  wire logic [1:0]  ctrl_mode_i,
    output logic      [7:0]  kp_mant_o,
    output logic      [1:0]  kp_exp10_o,
    output logic      [7:0]  ki_mant_o,
    output logic      [1:0]  ki_exp10_o,
    output logic             field_weaken_en_o,
    output logic      [3:0]  closed_loop_slow_ramp_o,
    output logic      [14:0] ramp_tenths_o,
    output logic      [19:0] ramp_unit_ppm_o,
    output logic      [2:0]  brake_slew_sel_o,
    output logic      [2:0]  misc_cfg_o,
    output logic             parity_o
);

    // ------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------
    // unit of one ramp step for the active control mode; all four codes of
    // the two mode bits are known, so the default branch only guards x states
    function automatic logic [19:0] atcr_unit_of(input logic [1:0] mode);
        logic [19:0] r;
        r = ATCR_UNIT_SPEED_PPM;
        case (atcr_mode_t'(mode))
            ATCR_MODE_SPEED:  r = ATCR_UNIT_SPEED_PPM;
            ATCR_MODE_POWER:  r = ATCR_UNIT_POWER_PPM;   // RULE_06
            ATCR_MODE_TORQUE: r = ATCR_UNIT_TORQUE_PPM;  // RULE_06
            ATCR_MODE_DUTY:   r = ATCR_UNIT_DUTY_PPM;    // RULE_06
            default:          r = ATCR_UNIT_SPEED_PPM;
        endcase
        return r;
    endfunction : atcr_unit_of

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    // the stored word and the bus answer
    logic [31:0] algorithm_tuning_config_two;
    logic [31:0] next_algorithm_tuning_config_two;
    logic        next_ack;
    logic [31:0] next_dat;
    logic        hit;

    // field slices taken from the stored word
    logic [9:0]  field_weaken_prop_gain;
    logic [9:0]  field_weaken_integ_gain;
    // gain halves from the two decoders
    logic [7:0]  kp_mant;
    logic [1:0]  kp_exp;
    logic [7:0]  ki_mant;
    logic [1:0]  ki_exp;
    logic [3:0]  closed_loop_slow_ramp;

    // ------------------------------------------------------------------
    // register layout
    // ------------------------------------------------------------------
    // 31     parity, stored only; no checking is done here
    // 30:21  field-weakening proportional gain: exponent 30:29, mantissa 28:21
    // 20:11  current-loop integral gain: exponent 20:19, mantissa 18:11
    // 10     field-weakening enable, one turns it on
    // 9:6    closed-loop slow ramp code, sixteen rates from 0.1 to 2000
    //        per second in the unit of the active control mode
    // 5:3    bus current slew select for active braking
    // 2:0    stored as written and handed out unchanged
    // the whole word clears to zero on reset and every bit is read/write

    assign field_weaken_prop_gain  = algorithm_tuning_config_two[ATCR_KP_LSB +: ATCR_GAIN_W];
    assign field_weaken_integ_gain = algorithm_tuning_config_two[ATCR_KI_LSB +: ATCR_GAIN_W];
    assign closed_loop_slow_ramp   = algorithm_tuning_config_two[ATCR_RAMP_LSB +: ATCR_RAMP_W];

    // ------------------------------------------------------------------
    // gain splitting
    // ------------------------------------------------------------------
    // only the split is done here; the 0.1 and 10 scales belong to the consumer
    atcr_gain_decode u_kp (                                  // RULE_01
        .gain_i  (field_weaken_prop_gain),
        .mant_o  (kp_mant),
        .exp10_o (kp_exp)
    );

    // the integral gain uses the same split as the proportional gain
    atcr_gain_decode u_ki (                                  // RULE_02
        .gain_i  (field_weaken_integ_gain),
        .mant_o  (ki_mant),
        .exp10_o (ki_exp)
    );

    // ------------------------------------------------------------------
    // bus slave next values
    // ------------------------------------------------------------------
    // one wait state: ack rises the cycle after the request and drops again
    // after one cycle; a request still held then is taken a second time, so
    // the master must release cyc/stb at the edge where it sees ack
    // the word is written at the edge that raises ack, and the read image is
    // the word as it stood before that edge
    // bits 1:0 of the address are ignored, any byte address in the word hits
    // byte lanes let software change one byte without a read first; every byte holds parts of two or more fields
    always_comb begin
        hit  = (wb_adr_i[9:2] == ATCR_TUNE_ADDR[9:2]);
        next_ack = wb_cyc_i & wb_stb_i & ~wb_ack_o;
        next_dat = ATCR_UNMAPPED_RD;
        next_algorithm_tuning_config_two = algorithm_tuning_config_two;
        if (next_ack && hit) begin
            next_dat = algorithm_tuning_config_two;                      // RULE_08
        end
        // write lands at the ack edge; byte lanes honour wb_sel_i
        if (next_ack && hit && wb_we_i) begin
            for (int b = 0; b < 4; b++) begin
                if (wb_sel_i[b]) begin
                    next_algorithm_tuning_config_two[8*b +: 8] = wb_dat_i[8*b +: 8]; // RULE_08
                end
            end
        end
    end

    // the word and the bus answer; reset clears both
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            algorithm_tuning_config_two <= ATCR_TUNE_RESET;             // RULE_08
            wb_ack_o                    <= 1'b0;
            wb_dat_o                    <= ATCR_UNMAPPED_RD;
        end else begin
            algorithm_tuning_config_two <= next_algorithm_tuning_config_two;
            wb_ack_o                    <= next_ack;
            wb_dat_o                    <= next_dat;
        end
    end

    // ------------------------------------------------------------------
    // algorithm-side outputs
    // ------------------------------------------------------------------
    // registered so every output is a flop; lags the register by one cycle
    // the lag costs a cycle of latency but keeps the algorithm side free of
    // paths that start at the bus inputs
    logic [7:0]  next_kp_mant;
    logic [1:0]  next_kp_exp;
    logic [7:0]  next_ki_mant;
    logic [1:0]  next_ki_exp;
    logic        next_fw_en;
    logic [3:0]  next_ramp;
    logic [14:0] next_ramp_tenths;
    logic [19:0] next_unit;
    logic [2:0]  next_slew;
    logic [2:0]  next_misc;
    logic        next_parity;

    // slices and lookups; the unit follows the mode pin, not the word, so a
    // mode change shows one cycle later without any register write
    // the table index is the four-bit code, so every entry is reachable
    always_comb begin
        next_kp_mant     = kp_mant;                                      // RULE_01
        next_kp_exp      = kp_exp;                                       // RULE_01
        next_ki_mant     = ki_mant;                                      // RULE_02
        next_ki_exp      = ki_exp;                                       // RULE_02
        next_fw_en       = algorithm_tuning_config_two[ATCR_FW_EN_BIT];  // RULE_03
        next_ramp        = closed_loop_slow_ramp;                        // RULE_04
        next_ramp_tenths = ATCR_RAMP_TENTHS[closed_loop_slow_ramp];      // RULE_04
        next_unit        = atcr_unit_of(ctrl_mode_i);                    // RULE_05
        next_slew        = algorithm_tuning_config_two[ATCR_SLEW_LSB +: ATCR_SLEW_W]; // RULE_07
        next_misc        = algorithm_tuning_config_two[ATCR_MISC_W-1:0]; // RULE_08
        // parity is stored only; its checking scheme lies outside this block
        next_parity      = algorithm_tuning_config_two[ATCR_PARITY_BIT];
    end

    // output flops; reset values are those of a cleared word in speed mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            kp_mant_o               <= 8'h00;
            kp_exp10_o              <= 2'h0;
            ki_mant_o               <= 8'h00;
            ki_exp10_o              <= 2'h0;
            field_weaken_en_o       <= 1'b0;
            closed_loop_slow_ramp_o <= 4'h0;
            ramp_tenths_o           <= ATCR_RAMP_TENTHS[0];
            ramp_unit_ppm_o         <= ATCR_UNIT_SPEED_PPM;
            brake_slew_sel_o        <= 3'h0;
            misc_cfg_o              <= 3'h0;
            parity_o                <= 1'b0;
        end else begin
            kp_mant_o               <= next_kp_mant;
            kp_exp10_o              <= next_kp_exp;
            ki_mant_o               <= next_ki_mant;
            ki_exp10_o              <= next_ki_exp;
            field_weaken_en_o       <= next_fw_en;
            closed_loop_slow_ramp_o <= next_ramp;
            ramp_tenths_o           <= next_ramp_tenths;
            ramp_unit_ppm_o         <= next_unit;
            brake_slew_sel_o        <= next_slew;
            misc_cfg_o              <= next_misc;
            parity_o                <= next_parity;
        end
    end

endmodule : atcr_tuning_reg

// >>> tb/atcr_tuning_reg_asserts.sv
// checker for the tuning register bus handshake and field outputs
`timescale 1ns/1ps
module atcr_tuning_reg_asserts
    import atcr_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic        wb_ack_o,
    input wire logic [9:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic [1:0]  ctrl_mode_i,
    input wire logic [1:0]  kp_exp10_o,
    input wire logic [1:0]  ki_exp10_o,
    input wire logic [7:0]  kp_mant_o,
    input wire logic [7:0]  ki_mant_o,
    input wire logic        field_weaken_en_o,
    input wire logic        parity_o,
    input wire logic [3:0]  closed_loop_slow_ramp_o,
    input wire logic [14:0] ramp_tenths_o,
    input wire logic [19:0] ramp_unit_ppm_o,
    input wire logic [2:0]  brake_slew_sel_o,
    input wire logic [2:0]  misc_cfg_o
);
    // unit and ramp tables kept apart from the package so a bad table there shows
    localparam logic [19:0] UNIT_TAB [4] = '{20'hf4240, 20'h186a0, 20'h2710, 20'h3e8};
    localparam logic [14:0] RAMP_TAB [16] = '{15'h1, 15'ha, 15'h14, 15'h1e, 15'h32, 15'h64,
        15'hc8, 15'h12c, 15'h190, 15'h1f4, 15'h3e8, 15'h7d0, 15'h1388, 15'h1d4c, 15'h2710,
        15'h4e20};
    logic [11:0] ctl;
    // ------------------------------------------------------------------
    // handshake and read image
    // ------------------------------------------------------------------
    // control bits gathered so one read compare covers them all
    assign ctl = {parity_o, field_weaken_en_o, closed_loop_slow_ramp_o, brake_slew_sel_o,
                  misc_cfg_o};
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence s_ack; wb_ack_o ##1 !wb_ack_o; endsequence
    sequence s_rd; wb_ack_o && !wb_we_i && wb_adr_i[9:2] == ATCR_TUNE_INDEX; endsequence
    a_ack_one_wait: assert property (s_req |=> s_ack)
        else $error("ack not a one cycle pulse after request");
    a_kp_read: assert property (s_rd |-> wb_dat_o[30:21] == {kp_exp10_o, kp_mant_o})
        else $error("kp output differs from register");
    a_ki_read: assert property (s_rd |-> wb_dat_o[20:11] == {ki_exp10_o, ki_mant_o})
        else $error("ki output differs from register");
    a_ctl_read: assert property (s_rd |-> {wb_dat_o[31], wb_dat_o[10:0]} == ctl)
        else $error("control outputs differ from register");
    a_unmapped_zero: assert property
        (wb_ack_o && wb_adr_i[9:2] != ATCR_TUNE_INDEX |-> wb_dat_o == 32'h0)
        else $error("unmapped access returned data");
    a_ramp_table: assert property
        (ramp_tenths_o == RAMP_TAB[closed_loop_slow_ramp_o])
        else $error("ramp magnitude does not match code");
    a_unit_mode: assert property
        (!$past(rst_i) |-> ramp_unit_ppm_o == UNIT_TAB[$past(ctrl_mode_i)])
        else $error("ramp unit does not follow mode");
    a_reset_zero: assert property
        ($past(rst_i) |-> !wb_ack_o && wb_dat_o == 32'h0 && ramp_unit_ppm_o == UNIT_TAB[0] &&
         {kp_exp10_o, kp_mant_o, ki_exp10_o, ki_mant_o, ctl} == 32'h0)
        else $error("outputs not cleared by reset");
endmodule : atcr_tuning_reg_asserts

bind atcr_tuning_reg atcr_tuning_reg_asserts i_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_ack_o, .wb_adr_i, .wb_dat_o, .ctrl_mode_i, .kp_exp10_o, .ki_exp10_o,
    .kp_mant_o, .ki_mant_o, .field_weaken_en_o, .parity_o, .closed_loop_slow_ramp_o,
    .ramp_tenths_o, .ramp_unit_ppm_o, .brake_slew_sel_o, .misc_cfg_o);

// >>> tb/atcr_tuning_reg_tb_top.sv
// self-checking bench for the algorithm tuning register
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; \
    $display("[FAIL] %s exp %0h got %0h", nm, e, g); end end
module atcr_tuning_reg_tb_top
    import atcr_pkg::*;
;
    logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [9:0]  wb_adr_i;
    logic [3:0]  wb_sel_i, closed_loop_slow_ramp_o;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [1:0]  ctrl_mode_i, kp_exp10_o, ki_exp10_o;
    logic [7:0]  kp_mant_o, ki_mant_o;
    logic        field_weaken_en_o, parity_o;
    logic [14:0] ramp_tenths_o;
    logic [19:0] ramp_unit_ppm_o;
    logic [2:0]  brake_slew_sel_o, misc_cfg_o;
    int          failures, num_checks;

    atcr_tuning_reg i_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .ctrl_mode_i, .kp_mant_o, .kp_exp10_o, .ki_mant_o,
        .ki_exp10_o, .field_weaken_en_o, .closed_loop_slow_ramp_o, .ramp_tenths_o,
        .ramp_unit_ppm_o, .brake_slew_sel_o, .misc_cfg_o, .parity_o);

    // 100 MHz clock
    always #5 clk_i = ~clk_i;

    // ------------------------------------------------------------------
    // bus and closing tasks
    // ------------------------------------------------------------------
    task automatic test_done;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : test_done

    // one classic cycle; holds everything until ack is seen at an edge
    task automatic xfer(input logic we, input logic [9:0] adr, input logic [31:0] d,
                        input logic [3:0] sel);
        int n;
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, we, adr, sel, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        if (n >= 20) begin
            failures++;
            test_done();
        end
    endtask : xfer

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset;
        #1;
        `CHK("kp", 10'h0, {kp_exp10_o, kp_mant_o})
        `CHK("tenths", 15'h1, ramp_tenths_o)
        xfer(1'b0, ATCR_TUNE_ADDR, 32'h0, 4'hf);
        `CHK("rd", 32'h0, rd)
        $display("reset test done");
    endtask : t_reset

    // a pattern and its inverse so every bit is seen at both levels
    task automatic t_fields;
        logic [31:0] w;
        for (int i = 0; i < 2; i++) begin
            w = {1'b1, 10'h25a, 10'h1a5, 1'b1, 4'hc, 3'h5, 3'h3} ^ {32{i[0]}};
            xfer(1'b1, ATCR_TUNE_ADDR, w, 4'hf);
            @(posedge clk_i);
            #1;
            `CHK("kp", w[30:21], {kp_exp10_o, kp_mant_o})
            `CHK("ki", w[20:11], {ki_exp10_o, ki_mant_o})
            `CHK("fw_en", w[10], field_weaken_en_o)
            `CHK("ramp", w[9:6], closed_loop_slow_ramp_o)
            `CHK("slew", w[5:3], brake_slew_sel_o)
            `CHK("misc", {w[31], w[2:0]}, {parity_o, misc_cfg_o})
            xfer(1'b0, ATCR_TUNE_ADDR | 10'h3, 32'h0, 4'hf);
            `CHK("rd", w, rd)
        end
        $display("fields test done");
    endtask : t_fields

    // byte lanes, then an unmapped write that must not land
    task automatic t_lanes;
        xfer(1'b1, ATCR_TUNE_ADDR, 32'ha5a5_a5a5, 4'hf);
        xfer(1'b1, ATCR_TUNE_ADDR, 32'h0, 4'h2);
        xfer(1'b1, ATCR_TUNE_ADDR + 10'h4, 32'hffff_ffff, 4'hf);
        xfer(1'b0, ATCR_TUNE_ADDR, 32'h0, 4'hf);
        `CHK("lanes", 32'ha5a5_00a5, rd)
        xfer(1'b0, ATCR_TUNE_ADDR + 10'h4, 32'h0, 4'hf);
        `CHK("unmapped", 32'h0, rd)
        $display("lanes test done");
    endtask : t_lanes

    task automatic t_ramp;
        logic [14:0] tab [16] = '{15'h1, 15'ha, 15'h14, 15'h1e, 15'h32, 15'h64, 15'hc8, 15'h12c,
            15'h190, 15'h1f4, 15'h3e8, 15'h7d0, 15'h1388, 15'h1d4c, 15'h2710, 15'h4e20};
        for (int c = 0; c < 16; c++) begin
            xfer(1'b1, ATCR_TUNE_ADDR, 32'(c) << 6, 4'hf);
            @(posedge clk_i);
            #1;
            `CHK("tenths", tab[c], ramp_tenths_o)
        end
        $display("ramp test done");
    endtask : t_ramp

    task automatic t_modes;
        logic [19:0] ppm [4] = '{20'hf4240, 20'h186a0, 20'h2710, 20'h3e8};
        for (int m = 3; m >= 0; m--) begin
            @(posedge clk_i);
            ctrl_mode_i <= 2'(m);
            @(posedge clk_i);
            #1;
            `CHK("unit", ppm[m], ramp_unit_ppm_o)
        end
        $display("modes test done");
    endtask : t_modes

    // reset in mid-run must clear a written word; the mode is moved so the
    // unit seen right after reset can only be the reset value
    task automatic t_rereset;
        xfer(1'b1, ATCR_TUNE_ADDR, 32'hffff_ffff, 4'hf);
        @(posedge clk_i);
        rst_i       <= 1'b1;
        ctrl_mode_i <= 2'h3;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        #1;
        `CHK("kp", 10'h0, {kp_exp10_o, kp_mant_o})
        `CHK("ki", 10'h0, {ki_exp10_o, ki_mant_o})
        `CHK("fw_ramp", 5'h0, {field_weaken_en_o, closed_loop_slow_ramp_o})
        `CHK("slew_misc", 7'h0, {parity_o, brake_slew_sel_o, misc_cfg_o})
        `CHK("tenths", 15'h1, ramp_tenths_o)
        `CHK("unit", 20'hf4240, ramp_unit_ppm_o)
        xfer(1'b0, ATCR_TUNE_ADDR, 32'h0, 4'hf);
        `CHK("rd", 32'h0, rd)
        $display("mid-run reset test done");
    endtask : t_rereset

    // reset for four edges, then the scenarios in turn
    initial begin
        {clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i} = 5'b01000;
        {wb_adr_i, wb_sel_i, wb_dat_i, ctrl_mode_i} = '0;
        {failures, num_checks} = '0;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_fields();
        t_lanes();
        t_ramp();
        t_modes();
        t_rereset();
        test_done();
    end
endmodule : atcr_tuning_reg_tb_top
